/* dual_timer_map.svh */
/*
  Register word indices, field positions, reset values and divider taps
  for the dual 8-bit interval timer.
  Assumes an Avalon-MM slave that uses word addresses.
*/
`ifndef DUAL_TIMER_MAP_SVH
`define DUAL_TIMER_MAP_SVH

// register word indices
`define IDX_PORT3_DIRECTION   16'hFF23
`define IDX_PORT3_LATCH       16'hFF03
`define IDX_TIMER_A_CTRL      16'hFF4C
`define IDX_TIMER_B_CTRL      16'hFF4E
`define IDX_TIMER_A_COMPARE   16'hFF4A
`define IDX_TIMER_B_COMPARE   16'hFF4B
`define IDX_TIMER_A_COUNT     16'hFF48
`define IDX_TIMER_B_COUNT     16'hFF49

// reset values
`define RST_PORT3_DIRECTION   8'hFF
`define RST_PORT3_LATCH       8'h00
`define RST_COMPARE           8'h00
`define PORT3_DIR_FIXED_ONES  8'hF0

// control register field positions
`define CTRL_RUN_BIT          7
`define CTRL_CLK_HI           5
`define CTRL_CLK_LO           3
`define CTRL_MODE_HI          2
`define CTRL_MODE_LO          1
`define CTRL_OE_BIT           0

// port-3 pins shared with the timers
`define PIN31                 1
`define PIN32                 2

// prescaler taps, as the number of low divider bits that must be all ones
`define TAP_A_DIV16           4
`define TAP_A_DIV256          8
`define TAP_B_DIV8            3
`define TAP_B_DIV128          7

`endif

/* dual_timer_pkg.sv */
/*
  Types shared by the dual 8-bit interval timer modules.
  Assumes dual_timer_map.svh is included by the users of the field numbers.
*/
package dual_timer_pkg;

  // one timer's control register as software sees it
  typedef struct packed {
    logic       run;       // timer_run_control
    logic       spare;
    logic [2:0] clk_sel;   // timer a uses the low two bits
    logic [1:0] mode;      // mode_select bits held here
    logic       out_en;    // timer_output_enable
  } timer_ctrl_t;

  // timer a count clock choices
  typedef enum logic [1:0] {
    clk_a_div16  = 2'h0,
    clk_a_div256 = 2'h1,
    clk_a_match  = 2'h2,
    clk_a_toggle = 2'h3
  } clk_a_sel_t;

  // bus answer sequencing
  typedef enum logic {
    bus_idle,
    bus_answer
  } bus_state_t;

endpackage : dual_timer_pkg

/* timer_channel.sv */
/*
  One 8-bit up-counter with compare, clear on match and toggling output.
  Assumes count_en is a one-cycle enable on the same clock.
*/
`timescale 1ns/100ps
module timer_channel
  import dual_timer_pkg::*;
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst_sync_n,
  // control
  input  wire logic       enable,
  input  wire logic       count_en,
  input  wire logic [7:0] compare,
  // results
  output logic [7:0]      count,
  output logic            match,
  output logic            wave
);

  // counter: cleared while stopped, cleared on match, else increments on count_en
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      count <= 8'h00;
    end else if (!enable) begin
      count <= 8'h00;
    end else if (count_en) begin
      count <= (count == compare) ? 8'h00 : count + 8'h01;
    end
  end

  // match pulse in the cycle the counter shows zero again
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      match <= 1'b0;
    end else begin
      match <= enable && count_en && (count == compare);
    end
  end

  // output inverts on each match, low while stopped
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wave <= 1'b0;
    end else if (!enable) begin
      wave <= 1'b0;
    end else if (count_en && (count == compare)) begin
      wave <= ~wave;
    end
  end

endmodule : timer_channel

/* dual_timer.sv */
/*
  Two 8-bit interval timers, prescalers, external count and port-3 registers.
  Assumes a single 250 MHz clock and an Avalon-MM master that honours waitrequest.
*/
// The Avalon-MM interface to the registers is this design's own decision.
// How it works
// - direction bit 0 drives pin, 1 floats
// - direction resets to all ones, top fixed
// - two counters in discrete mode, timer a can also count timer b matches or output toggles
// - only timer b counts external pulses
// - match clears counter, counting continues
// - interrupt raised as counter clears
// - timer a clock select four choices
// - timer b clock select six choices
// - run low clears and halts counter
// - all-zero mode bits select discrete mode
// - output enable routes timer to pin
// - external clock comes from pin 31
`timescale 1ns/100ps
`include "dual_timer_map.svh"
module dual_timer
  import dual_timer_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // avalon-mm slave
  input  wire logic [15:0] address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  // port-3 pins
  input  wire logic [3:0]  port3_in,
  output logic [3:0]       port3_out,
  output logic [3:0]       port3_oe,
  // interrupt requests
  output logic             timer_match_irq_a,
  output logic             timer_match_irq_b
);

  logic [1:0]  rst_pipe;
  logic        rst_sync_n;
  bus_state_t  bus_state;
  logic        wr_take;
  logic [7:0]  port3_direction;
  logic [7:0]  port3_latch;
  timer_ctrl_t ctrl_a, ctrl_b;
  logic [7:0]  timer_compare_a, timer_compare_b;
  logic [7:0]  timer_a_count_value, timer_b_count_value;
  logic        match_b;
  logic        wave_a, wave_b;
  logic        wave_b_q;
  logic [7:0]  divider;
  logic [3:0]  pin_meta, pin_sync;
  logic        ext_prev;
  logic        ext_edge;
  logic [2:0]  ext_div;
  logic        enable_a, enable_b;
  logic        tick_a, tick_b;
  logic [31:0] next_readdata;

  // true when the low n bits of v are all ones
  function automatic logic low_ones(input logic [7:0] v, input int n);
    return (v | (8'hFF << n)) == 8'hFF;
  endfunction : low_ones

  // reset release through two flops
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_pipe[1];

  // bus: one wait cycle, then answer with waitrequest low
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      bus_state   <= bus_idle;
      waitrequest <= 1'b1;
    end else begin
      case (bus_state)
        bus_idle: begin
          if (read || write) begin
            bus_state   <= bus_answer;
            waitrequest <= 1'b0;
          end
        end
        bus_answer: begin
          bus_state   <= bus_idle;
          waitrequest <= 1'b1;
        end
        default: begin
          bus_state   <= bus_idle;
          waitrequest <= 1'b1;
        end
      endcase
    end
  end
  assign wr_take = write && (bus_state == bus_answer);

  // read mux, unmapped words read zero
  always_comb begin
    next_readdata = 32'h0000_0000;
    case (address)
      `IDX_PORT3_DIRECTION: next_readdata[7:0] = port3_direction;
      `IDX_PORT3_LATCH:     next_readdata[7:0] = port3_latch;
      `IDX_TIMER_A_CTRL:    next_readdata[7:0] = ctrl_a;
      `IDX_TIMER_B_CTRL:    next_readdata[7:0] = ctrl_b;
      `IDX_TIMER_A_COMPARE: next_readdata[7:0] = timer_compare_a;
      `IDX_TIMER_B_COMPARE: next_readdata[7:0] = timer_compare_b;
      `IDX_TIMER_A_COUNT:   next_readdata[7:0] = timer_a_count_value;
      `IDX_TIMER_B_COUNT:   next_readdata[7:0] = timer_b_count_value;
      default:              next_readdata = 32'h0000_0000;
    endcase
  end

  // read data latched while the wait cycle runs
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      readdata <= 32'h0000_0000;
    end else if (read && bus_state == bus_idle) begin
      readdata <= next_readdata;
    end
  end

  // port-3 direction, upper nibble stuck at one, and latch
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      port3_direction <= `RST_PORT3_DIRECTION;
      port3_latch     <= `RST_PORT3_LATCH;
    end else if (wr_take) begin
      if (address == `IDX_PORT3_DIRECTION) begin
        port3_direction <= writedata[7:0] | `PORT3_DIR_FIXED_ONES;
      end
      if (address == `IDX_PORT3_LATCH) begin
        port3_latch <= writedata[7:0];
      end
    end
  end

  // timer control and compare registers, compare any value 00 to FF
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ctrl_a          <= '0;
      ctrl_b          <= '0;
      timer_compare_a <= `RST_COMPARE;
      timer_compare_b <= `RST_COMPARE;
    end else if (wr_take) begin
      if (address == `IDX_TIMER_A_CTRL) begin
        ctrl_a <= {writedata[`CTRL_RUN_BIT], 2'b00, writedata[`CTRL_CLK_LO+1:`CTRL_CLK_LO],
                   1'b0, writedata[`CTRL_MODE_LO], writedata[`CTRL_OE_BIT]};
      end
      if (address == `IDX_TIMER_B_CTRL) begin
        ctrl_b <= {writedata[`CTRL_RUN_BIT], 1'b0, writedata[`CTRL_CLK_HI:`CTRL_CLK_LO],
                   writedata[`CTRL_MODE_HI:`CTRL_MODE_LO], writedata[`CTRL_OE_BIT]};
      end
      if (address == `IDX_TIMER_A_COMPARE) begin
        timer_compare_a <= writedata[7:0];
      end
      if (address == `IDX_TIMER_B_COMPARE) begin
        timer_compare_b <= writedata[7:0];
      end
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      divider <= 8'h00;
    end else begin
      divider <= divider + 8'h01;
    end
  end

  // two-flop synchroniser, then rising edge of pin 31
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pin_meta <= 4'h0;
      pin_sync <= 4'h0;
      ext_prev <= 1'b0;
    end else begin
      pin_meta <= port3_in;
      pin_sync <= pin_meta;
      ext_prev <= pin_sync[`PIN31];
    end
  end
  assign ext_edge = pin_sync[`PIN31] && !ext_prev;

  // external edge divider, restarted while timer b stopped
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ext_div <= 3'h0;
    end else if (!enable_b) begin
      ext_div <= 3'h0;
    end else if (ext_edge) begin
      ext_div <= ext_div + 3'h1;
    end
  end

  // count only in discrete mode with run set
  assign enable_a = ctrl_a.run && ({ctrl_a.mode[0], ctrl_b.mode} == 3'h0);
  assign enable_b = ctrl_b.run && ({ctrl_a.mode[0], ctrl_b.mode} == 3'h0);

  always_comb begin
    case (clk_a_sel_t'(ctrl_a.clk_sel[1:0]))
      clk_a_div16:  tick_a = low_ones(divider, `TAP_A_DIV16);
      clk_a_div256: tick_a = low_ones(divider, `TAP_A_DIV256);
      clk_a_match:  tick_a = match_b;
      clk_a_toggle: tick_a = wave_b != wave_b_q;
      default:      tick_a = 1'b0;
    endcase
  end

  // timer b count clock choice, unused codes never tick
  always_comb begin
    case (ctrl_b.clk_sel)
      3'h0:    tick_b = low_ones(divider, `TAP_B_DIV8);
      3'h1:    tick_b = low_ones(divider, `TAP_B_DIV128);
      3'h2:    tick_b = ext_edge;
      3'h3:    tick_b = ext_edge && ext_div[0];
      3'h4:    tick_b = ext_edge && (ext_div[1:0] == 2'h3);
      3'h5:    tick_b = ext_edge && (ext_div == 3'h7);
      default: tick_b = 1'b0;
    endcase
  end

  // timer b output delayed to spot its transitions
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wave_b_q <= 1'b0;
    end else begin
      wave_b_q <= wave_b;
    end
  end

  timer_channel timer_a (
    .clock      (clock),
    .rst_sync_n (rst_sync_n),
    .enable     (enable_a),
    .count_en   (tick_a),
    .compare    (timer_compare_a),
    .count      (timer_a_count_value),
    .match      (),
    .wave       (wave_a)
  );
  timer_channel timer_b (
    .clock      (clock),
    .rst_sync_n (rst_sync_n),
    .enable     (enable_b),
    .count_en   (tick_b),
    .compare    (timer_compare_b),
    .count      (timer_b_count_value),
    .match      (match_b),
    .wave       (wave_b)
  );

  // one-cycle request in the cycle the counter clears
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      timer_match_irq_a <= 1'b0;
      timer_match_irq_b <= 1'b0;
    end else begin
      timer_match_irq_a <= enable_a && tick_a && (timer_a_count_value == timer_compare_a);
      timer_match_irq_b <= enable_b && tick_b && (timer_b_count_value == timer_compare_b);
    end
  end

  // pin drivers, timer output ORed with the latch bit when enabled
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      port3_out <= 4'h0;
      port3_oe  <= 4'h0;
    end else begin
      port3_oe  <= ~port3_direction[3:0];
      port3_out <= port3_latch[3:0];
      if (ctrl_a.out_en) begin
        port3_out[`PIN31] <= wave_a | port3_latch[`PIN31];
      end
      if (ctrl_b.out_en) begin
        port3_out[`PIN32] <= wave_b | port3_latch[`PIN32];
      end
    end
  end

endmodule : dual_timer

/* dual_timer_asserts.sv */
/*
  Port checker for the dual 8-bit interval timer.
  Assumes one clock domain and the bind at the foot of this file.
*/
`timescale 1ns/100ps
module dual_timer_asserts (
  // clock and reset
  input wire logic        clock,
  input wire logic        rst_n,
  // avalon-mm slave
  input wire logic [15:0] address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  // pins and requests
  input wire logic [3:0]  port3_oe,
  input wire logic        timer_match_irq_a,
  input wire logic        timer_match_irq_b
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // request pulses and pin drive
  irq_a_pulse_a: assert property (timer_match_irq_a |=> !timer_match_irq_a)
    else $error("timer a request wider than one cycle");
  irq_b_pulse_a: assert property (timer_match_irq_b |=> !timer_match_irq_b)
    else $error("timer b request wider than one cycle");
  dir_drives_oe_a: assert property (write && !waitrequest && address == 16'hFF23
    |-> ##2 port3_oe[0] == !$past(writedata[0], 2) && port3_oe[3] == !$past(writedata[3], 2))
    else $error("pin enable does not follow direction");
  dir_fixed_ones_a: assert property (read && !waitrequest && address == 16'hFF23
    |-> readdata[7:4] == 4'hF) else $error("direction top bits not one");
  stop_quiet_a: assert property (write && !waitrequest && address == 16'hFF4C
    && !writedata[7] |-> ##3 !timer_match_irq_a [*8]) else $error("stopped timer a fired");
  // bus answer
  answer_bound_a: assert property ((read || write) |-> ##[0:2] !waitrequest)
    else $error("bus request not answered");
  answer_once_a: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low too long");
  idle_wait_a: assert property (!read && !write |=> waitrequest)
    else $error("answer without request");
  upper_zero_a: assert property (!waitrequest |-> readdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
  unmapped_zero_a: assert property (read && !waitrequest && address == 16'h0000
    |-> readdata == 32'h00000000) else $error("unmapped read not zero");

  // main scenarios
  cov_irq_a: cover property (timer_match_irq_a);
  cov_irq_b: cover property (timer_match_irq_b);
  cov_dir_wr: cover property (write && !waitrequest && address == 16'hFF23);
endmodule : dual_timer_asserts

bind dual_timer dual_timer_asserts u_chk (.clock(clock), .rst_n(rst_n), .address(address),
  .read(read), .write(write), .writedata(writedata), .readdata(readdata),
  .waitrequest(waitrequest), .port3_oe(port3_oe), .timer_match_irq_a(timer_match_irq_a),
  .timer_match_irq_b(timer_match_irq_b));

/* dual_timer_tb_top.sv */
/*
  Self-checking bench for the dual 8-bit interval timer.
  Assumes the register map header and a bench-made pin 31 clock.
*/
`timescale 1ns/100ps
`include "dual_timer_map.svh"
module dual_timer_tb_top;
  logic        clock, rst_n, read, write, irq_a, irq_b, waitrequest, s;
  logic [15:0] address;
  logic [31:0] writedata, readdata, rd;
  logic [3:0]  port3_out, port3_oe;
  logic [3:0]  port3_in = 4'h0;
  logic [1:0]  pdiv = 2'h0;
  int          err_count, tests_run;

  dual_timer dut (.clock(clock), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .port3_in(port3_in), .port3_out(port3_out), .port3_oe(port3_oe),
    .timer_match_irq_a(irq_a), .timer_match_irq_b(irq_b));

  // clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // external count pin, rising edge every 8 cycles
  always @(posedge clock) begin
    pdiv <= pdiv + 2'h1;
    if (pdiv == 2'h3) port3_in[1] <= ~port3_in[1];
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("BAD at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check

  // one avalon transfer, held until waitrequest low
  task automatic bus(input logic wr, input logic [15:0] a, input logic [7:0] d);
    int k;
    address   <= a;
    writedata <= {24'h000000, d};
    read      <= !wr;
    write     <= wr;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (waitrequest !== 1'b0);
    check(k, 32'h2); // one wait cycle, answer sampled at second edge
    rd = readdata;
    read  <= 1'b0;
    write <= 1'b0;
    @(posedge clock);
  endtask : bus

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rchk(input logic [15:0] a, input logic [31:0] exp);
    bus(1'b0, a, 8'h00);
    check(rd, exp);
  endtask : rchk

  task automatic wait_irq(input logic b);
    do begin
      @(posedge clock);
    end while ((b ? irq_b : irq_a) !== 1'b1);
  endtask : wait_irq

  // cycles between two requests of one timer
  task automatic period(input logic b, input int exp);
    time t0;
    wait_irq(b);
    t0 = $time;
    wait_irq(b);
    check(32'(($time - t0) / 4), exp);
  endtask : period

  // stop, load, start, measure, stop
  task automatic run(input logic b, input logic [7:0] ctl, input logic [7:0] cmp,
                     input int exp);
    logic [15:0] c;
    c = b ? `IDX_TIMER_B_CTRL : `IDX_TIMER_A_CTRL;
    wr(c, 8'h00);
    wr(b ? `IDX_TIMER_B_COMPARE : `IDX_TIMER_A_COMPARE, cmp);
    wr(c, ctl);
    period(b, exp);
    wr(c, 8'h00);
    rchk(b ? `IDX_TIMER_B_COUNT : `IDX_TIMER_A_COUNT, 32'h0);
  endtask : run

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  // watchdog
  initial begin
    #200000;
    err_count++;
    wrap_up();
  end

  initial begin
    rst_n = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 16'h0000;
    writedata = 32'h0;
    err_count = 0;
    tests_run = 0;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    rchk(`IDX_PORT3_DIRECTION, 32'hFF);
    rchk(`IDX_TIMER_A_CTRL, 32'h0);
    rchk(`IDX_TIMER_B_COMPARE, 32'h0);
    rchk(16'h0000, 32'h0);
    check({28'h0, port3_oe}, 32'h0);
    wr(`IDX_PORT3_DIRECTION, 8'h0B);
    rchk(`IDX_PORT3_DIRECTION, 32'hFB);
    check({28'h0, port3_oe}, 32'h4);
    wr(`IDX_TIMER_A_COUNT, 8'h55);
    rchk(`IDX_TIMER_A_COUNT, 32'h0);
    $display("registers done");
    run(1'b0, 8'h80, 8'h03, 64);
    run(1'b0, 8'h88, 8'h00, 256);
    run(1'b1, 8'h80, 8'h04, 40);
    run(1'b1, 8'h88, 8'h01, 256);
    $display("prescaled intervals done");
    run(1'b1, 8'h90, 8'h02, 24);
    run(1'b1, 8'h98, 8'h02, 48);
    run(1'b1, 8'hA0, 8'h02, 96);
    run(1'b1, 8'hA8, 8'h02, 192);
    $display("external count done");
    wr(`IDX_TIMER_B_COMPARE, 8'h01);
    wr(`IDX_TIMER_B_CTRL, 8'h81);
    run(1'b0, 8'h80, 8'h03, 64);
    run(1'b0, 8'h90, 8'h01, 32);
    run(1'b0, 8'h98, 8'h01, 32);
    $display("cascade clock done");
    wait_irq(1'b1);
    repeat (4) @(posedge clock);
    s = port3_out[2];
    wait_irq(1'b1);
    repeat (4) @(posedge clock);
    check({31'h0, port3_out[2]}, {31'h0, ~s});
    wr(`IDX_TIMER_B_CTRL, 8'h80);
    repeat (20) @(posedge clock);
    check({31'h0, port3_out[2]}, 32'h0);
    wr(`IDX_PORT3_LATCH, 8'h0C);
    rchk(`IDX_PORT3_LATCH, 32'hC);
    check({28'h0, port3_out}, 32'hC);
    wr(`IDX_PORT3_LATCH, 8'h00);
    wr(`IDX_PORT3_DIRECTION, 8'h09);
    wr(`IDX_TIMER_A_CTRL, 8'h81);
    wait_irq(1'b0);
    repeat (4) @(posedge clock);
    s = port3_out[1];
    wait_irq(1'b0);
    repeat (4) @(posedge clock);
    check({31'h0, port3_out[1]}, {31'h0, ~s});
    check({28'h0, port3_oe}, 32'h6);
    $display("output pin done");
    wrap_up();
  end
endmodule : dual_timer_tb_top
